// ---- adc_ctrl_cfg.svh ----
// Purpose: Named offsets, field positions and timing counts
// Assumes: Included by the control block and its testbench
// Notes: Register offsets are word indices; byte address is four times
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// ============================================================
// Register word indices
`define IDX_CTRL1 16'h7100
`define IDX_CTRL2 16'h7101
`define IDX_MAXCONV 16'h7102
`define IDX_CHSEL0 16'h7103
`define IDX_SEQSTAT 16'h7107
`define IDX_RESULT0 16'h7108
`define IDX_CTRL3 16'h7118
`define IDX_STATUS 16'h7119
`define IDX_REFSEL 16'h711c

// ============================================================
// Field positions
`define C1_CASCADE 4
`define C1_STARTSTOP 6
`define C1_ACQ_LSB 8
`define C2_PWMB_EN2 0
`define C2_INT_MODE2 2
`define C2_INT_EN2 3
`define C2_SW_SOC2 5
`define C2_RST2 6
`define C2_PWMA_EN1 8
`define C2_INT_MODE1 10
`define C2_INT_EN1 11
`define C2_SW_SOC1 13
`define C2_RST1 14
`define C2_PIN_EN1 15
`define MAX2_LSB 4
`define SS_PTR2_LSB 4
`define RESULT_LSB 4
`define C3_DIV_LSB 0
`define ST_FLAG1 0
`define ST_FLAG2 1
`define ST_BUSY1 2
`define ST_BUSY2 3
`define ST_CLR1 4
`define ST_CLR2 5
`define REF_LSB 14

// ============================================================
// Timing
`define PCLK_MHZ 50
`define CONV_CLK_MHZ 25
`define CONV_NS 80
`define BASE_DIV (`PCLK_MHZ / `CONV_CLK_MHZ)
`define CONV_TICKS ((`CONV_NS * `CONV_CLK_MHZ + 999) / 1000)

`endif

// ---- adc_ctrl_pkg.sv ----
// Purpose: Types shared by the converter control modules
// Assumes: Nothing beyond the standard language
// Notes: The control, sync and divider modules each keep all of their state in one struct
package adc_ctrl_pkg;

    // ============================================================
    // Sequencer states, Gray along idle-acquire-convert-done
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ACQ = 2'b01,
        SEQ_CONV = 2'b11,
        SEQ_DONE = 2'b10
    } seq_state_e;

    // ============================================================
    // Main state
    typedef struct packed {
        logic cascade;
        logic start_stop;
        logic [3:0] acq_ps;
        logic pwma_en;
        logic pwmb_en;
        logic pin_en;
        logic [1:0] int_mode;
        logic [1:0] int_en;
        logic [6:0] maxconv;
        logic [15:0][3:0] chsel;
        logic [15:0][11:0] result;
        logic [3:0] clk_div;
        logic [1:0] ref_sel;
        logic pend1;
        logic pend2;
        logic [3:0] ptr1;
        logic [2:0] ptr2;
        logic [1:0] eos_odd;
        logic [1:0] eos_flag;
        seq_state_e state;
        logic cur_seq;
        logic [3:0] cnt;
        logic [3:0] seen;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic conv_start;
        logic [3:0] conv_channel;
        logic sample_hold;
        logic power_up;
        logic irq1;
        logic irq2;
    } ctrl_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
    } sync_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } div_s;

endpackage

// ---- pin_rise_sync.sv ----
// Purpose: Synchronise a pin and report a filtered rising edge
// Assumes: Pin is asynchronous to pclk
// Notes: A change counts once the second and third stages agree
`timescale 1ns/1ps
module pin_rise_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic rise
);
    adc_ctrl_pkg::sync_s q;
    adc_ctrl_pkg::sync_s d;

    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rise = 1'b0;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
            d.rise = q.s3 & ~q.lvl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise = q.rise;
endmodule // pin_rise_sync

// ---- conv_tick_divider.sv ----
// Purpose: Converter clock as a one-cycle enable pulse
// Assumes: period_m1 holds the pulse period minus one
// Notes: Counter restarts whenever run is low so ticks align to a start
`timescale 1ns/1ps
module conv_tick_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [7:0] period_m1,
    output logic tick
);
    adc_ctrl_pkg::div_s q;
    adc_ctrl_pkg::div_s d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!run) begin
            d.cnt = '0;
        end else if (q.cnt >= period_m1) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule // conv_tick_divider

// ---- adc_autosequencer_control.sv ----
// Purpose: Sequencer, triggers and APB registers around one converter
// Assumes: Converter core returns a saturated 12-bit code on conv_data
// Notes: Clock gate and halt come from system control on pclk
//
// What this block does
// - In cascade mode each step picks any of sixteen channels, up to sixteen steps.
// - Runs as two 8-step sequencers or one cascaded 16-step one.
// - Dual mode keeps each sequencer in its own eight channels.
// - Each finished conversion lands in the current step's result.
// - Sixteen result registers, each readable on its own.
// - Codes span 0 to 4095, saturating at both reference ends.
// - Software, PWM trigger or external pin starts a sequence.
// - Sequence-end request fires every end or every second end.
// - Start/stop mode pauses after each triggered step.
// - PWM triggers A and B start their own sequencers separately.
// - Acquisition window has its own prescale, apart from divider.
// - One converter, so requests of both sequencers are serialised.
// - A channel may appear in several steps for oversampling.
// - A conversion lasts 80 ns of a 25 MHz converter clock.
// - Registers run on pclk; sequencing on a divided tick.
// - Under reset all goes to defaults and analog stays powered off.
// - Gate low blocks register writes; gate high enables analog.
// - Halt powers analog down and keeps all register contents.
// - Reference select sits in bits 15 to 14 of its register.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_autosequencer_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [17:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic converter_clock_gate_enable,
    input wire logic halt_mode,
    input wire logic pwm_conv_trigger_a,
    input wire logic pwm_conv_trigger_b,
    input wire logic external_irq_line_two,
    input wire logic [11:0] conv_data,
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic sample_hold,
    output logic analog_power_up,
    output logic [1:0] external_ref_select,
    output logic seq1_irq,
    output logic seq2_irq
);
    adc_ctrl_pkg::ctrl_s q;
    adc_ctrl_pkg::ctrl_s d;
    logic pin_rise;
    logic tick;
    logic run_ok;
    logic wr;
    logic hit;
    logic [15:0] widx;
    logic [31:0] rdat;
    logic trig1;
    logic trig2;
    logic [3:0] cur_slot;
    logic [3:0] cur_max;
    logic cur_ptr_last;
    logic [7:0] period_m1;

    // ============================================================
    // Helpers
    function automatic logic [3:0] slot_of(input logic seq,
        input logic [3:0] p1, input logic [2:0] p2);
        slot_of = seq ? {1'b1, p2} : p1;
    endfunction

    function automatic logic [3:0] chan_of(input logic [3:0] sel,
        input logic casc, input logic seq);
        chan_of = casc ? sel : {seq, sel[2:0]};
    endfunction

    // ============================================================
    // Trigger pin and converter tick
    pin_rise_sync u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .pin(external_irq_line_two),
        .rise(pin_rise)
    );

    // Stretching the divider slows acquisition and conversion alike
    assign period_m1 = 8'(`BASE_DIV * (int'(q.clk_div) + 1) - 1);

    conv_tick_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_ok && q.state != adc_ctrl_pkg::SEQ_IDLE),
        .period_m1(period_m1),
        .tick(tick)
    );

    // ============================================================
    // Next state
    always_comb begin
        d = q;
        run_ok = converter_clock_gate_enable & ~halt_mode;
        widx = paddr[17:2];
        wr = psel & penable & q.pready & pwrite;
        rdat = '0;
        hit = 1'b1;
        cur_slot = slot_of(q.cur_seq, q.ptr1, q.ptr2);
        cur_max = q.cur_seq ? {1'b0, q.maxconv[`MAX2_LSB +: 3]} :
            (q.cascade ? q.maxconv[3:0] : {1'b0, q.maxconv[2:0]});
        cur_ptr_last = q.cur_seq ? ({1'b0, q.ptr2} == cur_max) :
            (q.ptr1 == cur_max);
        d.conv_start = 1'b0;
        d.irq1 = 1'b0;
        d.irq2 = 1'b0;
        d.power_up = run_ok;
        // Register decode
        if (widx == `IDX_CTRL1) begin
            rdat[`C1_CASCADE] = q.cascade;
            rdat[`C1_STARTSTOP] = q.start_stop;
            rdat[`C1_ACQ_LSB +: 4] = q.acq_ps;
        end else if (widx == `IDX_CTRL2) begin
            rdat[`C2_PWMB_EN2] = q.pwmb_en;
            rdat[`C2_INT_MODE2] = q.int_mode[1];
            rdat[`C2_INT_EN2] = q.int_en[1];
            rdat[`C2_PWMA_EN1] = q.pwma_en;
            rdat[`C2_INT_MODE1] = q.int_mode[0];
            rdat[`C2_INT_EN1] = q.int_en[0];
            rdat[`C2_PIN_EN1] = q.pin_en;
        end else if (widx == `IDX_MAXCONV) begin
            rdat[6:0] = q.maxconv;
        end else if (widx == `IDX_SEQSTAT) begin
            rdat[3:0] = q.ptr1;
            rdat[`SS_PTR2_LSB +: 3] = q.ptr2;
        end else if (widx == `IDX_CTRL3) begin
            rdat[`C3_DIV_LSB +: 4] = q.clk_div;
        end else if (widx == `IDX_STATUS) begin
            rdat[`ST_FLAG1] = q.eos_flag[0];
            rdat[`ST_FLAG2] = q.eos_flag[1];
            rdat[`ST_BUSY1] = q.pend1;
            rdat[`ST_BUSY2] = q.pend2;
        end else if (widx == `IDX_REFSEL) begin
            rdat[`REF_LSB +: 2] = q.ref_sel;
        end else begin
            hit = 1'b0;
        end
        for (int j = 0; j < 4; j++) begin
            if (widx == `IDX_CHSEL0 + 16'(j)) begin
                hit = 1'b1;
                rdat[15:0] = q.chsel[4*j +: 4];
            end
        end
        for (int k = 0; k < 16; k++) begin
            if (widx == `IDX_RESULT0 + 16'(k)) begin
                hit = 1'b1;
                rdat[`RESULT_LSB +: 12] = q.result[k];
            end
        end
        // APB answer one cycle into the access phase
        d.pready = psel & penable & ~q.pready;
        if (psel & penable & ~q.pready) begin
            d.prdata = rdat;
            d.pslverr = ~hit;
        end
        // Writes take effect only with the register clock running
        trig1 = 1'b0;
        trig2 = 1'b0;
        if (wr && hit && converter_clock_gate_enable) begin
            if (widx == `IDX_CTRL1) begin
                d.cascade = pwdata[`C1_CASCADE];
                d.start_stop = pwdata[`C1_STARTSTOP];
                d.acq_ps = pwdata[`C1_ACQ_LSB +: 4];
            end
            if (widx == `IDX_CTRL2) begin
                d.pwmb_en = pwdata[`C2_PWMB_EN2];
                d.int_mode[1] = pwdata[`C2_INT_MODE2];
                d.int_en[1] = pwdata[`C2_INT_EN2];
                d.pwma_en = pwdata[`C2_PWMA_EN1];
                d.int_mode[0] = pwdata[`C2_INT_MODE1];
                d.int_en[0] = pwdata[`C2_INT_EN1];
                d.pin_en = pwdata[`C2_PIN_EN1];
                trig1 = pwdata[`C2_SW_SOC1];
                trig2 = pwdata[`C2_SW_SOC2] & ~q.cascade;
            end
            if (widx == `IDX_MAXCONV) begin
                d.maxconv = pwdata[6:0];
            end
            if (widx == `IDX_CTRL3) begin
                d.clk_div = pwdata[`C3_DIV_LSB +: 4];
            end
            if (widx == `IDX_STATUS) begin
                if (pwdata[`ST_CLR1]) begin
                    d.eos_flag[0] = 1'b0;
                end
                if (pwdata[`ST_CLR2]) begin
                    d.eos_flag[1] = 1'b0;
                end
            end
            if (widx == `IDX_REFSEL) begin
                d.ref_sel = pwdata[`REF_LSB +: 2];
            end
            for (int j = 0; j < 4; j++) begin
                if (widx == `IDX_CHSEL0 + 16'(j)) begin
                    // Repeated channel numbers are legal
                    d.chsel[4*j +: 4] = pwdata[15:0];
                end
            end
        end
        // Trigger sources, each to its own sequencer
        trig1 = trig1 | (pwm_conv_trigger_a & q.pwma_en) |
            (pin_rise & q.pin_en);
        trig2 = trig2 | (pwm_conv_trigger_b & q.pwmb_en & ~q.cascade);
        if (run_ok && trig1) begin
            d.pend1 = 1'b1;
        end
        if (run_ok && trig2) begin
            d.pend2 = 1'b1;
        end
        // Sequencer reset aborts a step in flight on that sequencer
        if (wr && converter_clock_gate_enable && widx == `IDX_CTRL2) begin
            if (pwdata[`C2_RST1]) begin
                d.ptr1 = '0;
                d.pend1 = 1'b0;
            end
            if (pwdata[`C2_RST2]) begin
                d.ptr2 = '0;
                d.pend2 = 1'b0;
            end
            if ((pwdata[`C2_RST1] && !q.cur_seq) ||
                (pwdata[`C2_RST2] && q.cur_seq)) begin
                d.state = adc_ctrl_pkg::SEQ_IDLE;
                d.sample_hold = 1'b0;
            end
        end
        // Shared converter, frozen while halted or gated off
        if (run_ok && d.state == q.state) begin
            unique case (q.state)
                adc_ctrl_pkg::SEQ_IDLE: begin
                    if (q.pend1 || q.pend2) begin
                        d.cur_seq = ~q.pend1;
                        d.state = adc_ctrl_pkg::SEQ_ACQ;
                        d.cnt = q.acq_ps;
                        d.sample_hold = 1'b1;
                        d.conv_channel = chan_of(q.chsel[slot_of(~q.pend1,
                            q.ptr1, q.ptr2)], q.cascade, ~q.pend1);
                    end
                end
                adc_ctrl_pkg::SEQ_ACQ: begin
                    if (tick && q.cnt == 4'h0) begin
                        d.state = adc_ctrl_pkg::SEQ_CONV;
                        d.sample_hold = 1'b0;
                        d.conv_start = 1'b1;
                        d.cnt = 4'(`CONV_TICKS - 1);
                        d.seen = 4'h0;
                    end else if (tick) begin
                        d.cnt = q.cnt - 4'h1;
                    end
                end
                adc_ctrl_pkg::SEQ_CONV: begin
                    if (tick) begin
                        d.seen = q.seen + 4'h1;
                    end
                    if (tick && q.cnt == 4'h0) begin
                        d.state = adc_ctrl_pkg::SEQ_DONE;
                        // Core saturates at both reference ends
                        d.result[cur_slot] = conv_data;
                    end else if (tick) begin
                        d.cnt = q.cnt - 4'h1;
                    end
                end
                adc_ctrl_pkg::SEQ_DONE: begin
                    d.state = adc_ctrl_pkg::SEQ_IDLE;
                    if (cur_ptr_last) begin
                        // Sequence end sets the flag over a same-cycle clear
                        d.eos_flag[q.cur_seq] = 1'b1;
                        d.eos_odd[q.cur_seq] = ~q.eos_odd[q.cur_seq];
                        if (q.cur_seq) begin
                            d.ptr2 = '0;
                            d.pend2 = 1'b0;
                            d.irq2 = q.int_en[1] &
                                (~q.int_mode[1] | q.eos_odd[1]);
                        end else begin
                            d.ptr1 = '0;
                            d.pend1 = 1'b0;
                            d.irq1 = q.int_en[0] &
                                (~q.int_mode[0] | q.eos_odd[0]);
                        end
                    end else if (q.cur_seq) begin
                        d.ptr2 = q.ptr2 + 3'h1;
                        d.pend2 = d.pend2 & ~q.start_stop;
                    end else begin
                        d.ptr1 = q.ptr1 + 4'h1;
                        d.pend1 = d.pend1 & ~q.start_stop;
                    end
                end
            endcase
        end
    end

    // Everything defaults under reset, analog held off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ============================================================
    // Outputs
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign conv_start = q.conv_start;
    assign conv_channel = q.conv_channel;
    assign sample_hold = q.sample_hold;
    assign analog_power_up = q.power_up;
    assign external_ref_select = q.ref_sel;
    assign seq1_irq = q.irq1;
    assign seq2_irq = q.irq2;

    // ============================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable && !pready ##1 pready;
    endsequence

    sequence s_acq_end;
        q.state == adc_ctrl_pkg::SEQ_ACQ && sample_hold
            ##1 conv_start && !sample_hold;
    endsequence

    AST_APB_ANSWER: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB answer not one cycle late");
    AST_ACQ_THEN_CONV: assert property (
        conv_start |-> $past(sample_hold))
        else $error("Conversion started without acquisition");
    AST_ACQ_SEQ: assert property (
        s_acq_end |=> q.state == adc_ctrl_pkg::SEQ_CONV)
        else $error("Acquisition did not lead into conversion");
    AST_PRIORITY: assert property (
        q.state == adc_ctrl_pkg::SEQ_IDLE && q.pend1 && run_ok
        |=> q.state != adc_ctrl_pkg::SEQ_ACQ || !q.cur_seq)
        else $error("Second sequencer served ahead of first");
    AST_GROUP: assert property (
        q.state == adc_ctrl_pkg::SEQ_ACQ && !q.cascade
        |-> conv_channel[3] == q.cur_seq)
        else $error("Channel outside its sequencer group");
    AST_SERIAL: assert property (
        q.state != adc_ctrl_pkg::SEQ_IDLE
        && $past(q.state) != adc_ctrl_pkg::SEQ_IDLE |-> $stable(q.cur_seq))
        else $error("Sequencer switched mid conversion");
    AST_CONV_LEN: assert property (
        q.state == adc_ctrl_pkg::SEQ_CONV ##1
        q.state == adc_ctrl_pkg::SEQ_DONE |-> q.seen == 4'(`CONV_TICKS))
        else $error("Conversion length wrong");
    AST_STORE: assert property (
        q.state == adc_ctrl_pkg::SEQ_CONV && tick && q.cnt == 4'h0
        && run_ok |=> q.result[$past(cur_slot)] == $past(conv_data))
        else $error("Result not stored in step slot");
    AST_GATE_WR: assert property (
        wr && !converter_clock_gate_enable |=> $stable(q.cascade)
        && $stable(q.ref_sel) && $stable(q.maxconv))
        else $error("Write taken with clock gate low");
    AST_HALT_PWR: assert property (
        halt_mode |=> !analog_power_up)
        else $error("Analog powered during halt");
    AST_REFSEL: assert property (
        wr && converter_clock_gate_enable && widx == `IDX_REFSEL
        |=> external_ref_select == $past(pwdata[15:14]))
        else $error("Reference select not taken from 15:14");
endmodule // adc_autosequencer_control

// ---- conv_core_model.sv ----
// Purpose: Behavioural converter core facing the control block
// Assumes: One conversion per conv_start pulse
// Notes: Code carries the channel so misplaced results show up
`timescale 1ns/1ps
module conv_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    input wire logic [3:0] conv_channel,
    input wire logic sample_hold,
    output logic [11:0] conv_data
);
    // ============================================================
    // Code is valid from start until the next acquisition; after
    // that the bus shows the inverse so a late sample is caught
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_data <= 12'h000;
        end else if (conv_start) begin
            conv_data <= {conv_channel, 8'h3c};
        end else if (sample_hold) begin
            conv_data <= ~{conv_channel, 8'h3c};
        end
    end
endmodule // conv_core_model

// ---- tb_adc_autosequencer_control.sv ----
// Purpose: Register-level test of the converter control
// Assumes: Converter model answers every conversion
// Notes: Triggers are same-clock pulses, pin is held for several cycles
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module tb_adc_autosequencer_control;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic gate, halt, trg_a, trg_b, pin, conv_start, sample_hold, pwr;
    logic irq1, irq2;
    logic [11:0] conv_data;
    logic [3:0] conv_channel;
    logic [1:0] ref_sel;
    logic [3:0] chq[$];
    logic [3:0] dch[4] = '{4'h3, 4'h6, 4'hf, 4'ha};
    logic [3:0] dix[4] = '{4'h0, 4'h1, 4'h8, 4'h9};
    integer miscompares, checks_done, irq1_n, irq2_n, i;
    // ============================================================
    // Clock, design and converter
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    adc_autosequencer_control u_dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .converter_clock_gate_enable(gate),
        .halt_mode(halt), .pwm_conv_trigger_a(trg_a),
        .pwm_conv_trigger_b(trg_b), .external_irq_line_two(pin),
        .conv_data(conv_data), .conv_start(conv_start),
        .conv_channel(conv_channel), .sample_hold(sample_hold),
        .analog_power_up(pwr), .external_ref_select(ref_sel),
        .seq1_irq(irq1), .seq2_irq(irq2));
    conv_core_model u_core (.pclk(pclk), .presetn(presetn),
        .conv_start(conv_start), .conv_channel(conv_channel),
        .sample_hold(sample_hold), .conv_data(conv_data));
    always @(posedge pclk) begin
        if (conv_start === 1'b1) chq.push_back(conv_channel);
        if (irq1 === 1'b1) irq1_n++;
        if (irq2 === 1'b1) irq2_n++;
    end
    // ============================================================
    // Shared tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Idle edge first, so back-to-back calls never drive psel twice
    task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        integer n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            results;
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulse_a;
        trg_a <= 1'b1;
        @(posedge pclk);
        trg_a <= 1'b0;
    endtask
    task wait_st(input logic [31:0] m);
        integer n;
        n = 0;
        do begin
            apb(1'b0, `IDX_STATUS, 32'h0);
            n++;
        end while ((r & m) !== m && n < 300);
        if (n >= 300) begin
            miscompares++;
            results;
        end
    endtask
    // ============================================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, gate, halt, trg_a, trg_b, pin} = 0;
        paddr = 18'h0;
        pwdata = 32'h0;
        {miscompares, checks_done, irq1_n, irq2_n} = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pwr, 32'h0);
        apb(1'b1, `IDX_REFSEL, 32'hc000);
        apb(1'b0, `IDX_REFSEL, 32'h0);
        chk(r, 32'h0);
        gate <= 1'b1;
        // Settling wait, scaled down from milliseconds
        repeat (4) @(posedge pclk);
        apb(1'b1, `IDX_REFSEL, 32'h8000);
        apb(1'b0, `IDX_REFSEL, 32'h0);
        chk(r, 32'h8000);
        chk(ref_sel, 32'h2);
        chk(pwr, 32'h1);
        apb(1'b0, 16'h711a, 32'h0);
        chk(err, 32'h1);
        halt <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(pwr, 32'h0);
        apb(1'b0, `IDX_REFSEL, 32'h0);
        chk(r, 32'h8000);
        halt <= 1'b0;
        // Cascade, two channels twice each, software start
        apb(1'b1, `IDX_CTRL1, 32'h10);
        apb(1'b1, `IDX_MAXCONV, 32'h3);
        apb(1'b1, `IDX_CHSEL0, 32'h5a5a);
        apb(1'b1, `IDX_CTRL2, 32'h2800);
        wait_st(32'h1);
        for (i = 0; i < 4; i++) begin
            apb(1'b0, `IDX_RESULT0 + 16'(i), 32'h0);
            chk(r, {16'h0, i[0] ? 4'h5 : 4'ha, 8'h3c, 4'h0});
            chk(chq[i], i[0] ? 32'h5 : 32'ha);
        end
        chk(irq1_n, 32'h1);
        // Dual, both PWM triggers in one cycle
        chq.delete();
        apb(1'b1, `IDX_STATUS, 32'h30);
        apb(1'b1, `IDX_CTRL1, 32'h0);
        apb(1'b1, `IDX_MAXCONV, 32'h11);
        apb(1'b1, `IDX_CHSEL0, 32'h0063);
        apb(1'b1, `IDX_CHSEL0 + 16'h2, 32'h0027);
        apb(1'b1, `IDX_CTRL2, 32'h4040);
        apb(1'b1, `IDX_CTRL2, 32'h0109);
        trg_a <= 1'b1;
        trg_b <= 1'b1;
        @(posedge pclk);
        trg_a <= 1'b0;
        trg_b <= 1'b0;
        wait_st(32'h3);
        for (i = 0; i < 4; i++) begin
            chk(chq[i], dch[i]);
            apb(1'b0, `IDX_RESULT0 + 16'(dix[i]), 32'h0);
            chk(r, {16'h0, dch[i], 8'h3c, 4'h0});
        end
        // Pin start, request on every second end
        apb(1'b1, `IDX_CTRL2, 32'h8c00);
        repeat (2) begin
            apb(1'b1, `IDX_STATUS, 32'h30);
            pin <= 1'b1;
            wait_st(32'h1);
            pin <= 1'b0;
            repeat (6) @(posedge pclk);
        end
        chk(irq1_n, 32'h2);
        chk(chq.size(), 32'h8);
        chk(irq2_n, 32'h1);
        // Start/stop: one step per trigger, slow tick, long acquisition
        apb(1'b1, `IDX_STATUS, 32'h30);
        apb(1'b1, `IDX_CTRL1, 32'h340);
        apb(1'b1, `IDX_CTRL3, 32'h1);
        apb(1'b1, `IDX_CTRL2, 32'h0100);
        pulse_a;
        repeat (60) @(posedge pclk);
        apb(1'b0, `IDX_SEQSTAT, 32'h0);
        chk(r, 32'h1);
        chk(chq.size(), 32'h9);
        pulse_a;
        wait_st(32'h1);
        chk(chq.size(), 32'ha);
        chk(chq[9], 32'h6);
        apb(1'b0, `IDX_SEQSTAT, 32'h0);
        chk(r, 32'h0);
        results;
    end
endmodule // tb_adc_autosequencer_control
